// ===== flash_host_pkg.sv
package flash_host_pkg;
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 10;
  // timing figures in ns; values are plain defaults for the pin timings
  localparam int MIN_RESET_PULSE_TIME_NS = 100;
  localparam int RESET_TO_SELECT_DELAY_NS = 50;
  localparam int RESET_TO_WRITE_STROBE_DELAY_NS = 50;
  localparam int READ_ACCESS_NS = 100;
  localparam int WRITE_PULSE_NS = 40;
  localparam int WRITE_HOLD_NS = 30;
  localparam int RESET_PULSE_CYC = (MIN_RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_SEL_CYC = (RESET_TO_SELECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_WE_CYC = (RESET_TO_WRITE_STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (REL_SEL_CYC > REL_WE_CYC) ? REL_SEL_CYC : REL_WE_CYC;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHOLD_CYC = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam int BYTE_W = 8;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    ST_RESET, ST_RELEASE, ST_IDLE, ST_READ, ST_WRITE_LOW, ST_WRITE_HOLD
  } host_state_t;
endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  always_comb begin
    meta_d = enable_in ? async_in : meta_q;
    sync_d = enable_in ? meta_q : sync_q;
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== flash_host.sv
// What this block does
// RQ1 - address selects read cell or command
// RQ2 - select high means standby, data floated
// RQ3 - output gate low enables device drivers
// RQ4 - address on strobe fall, data on rise
// RQ5 - width select low byte, high word
// RQ6 - width select steady during byte writes
// RQ7 - reset held low at least minimum time
// RQ8 - wait later release delay before access
// RQ9 - low byte carries data and commands
// RQ10 - lanes 14..8 read only in word mode
// RQ11 - ignore lanes 14..8 in polling status
// RQ12 - top pin is data15 or address lsb
// RQ13 - busy pin low during program/erase
// RQ14 - busy released otherwise, shared pull-up
// RQ15 - protect input low guards end block
// RQ16 - later fall latches address, earlier rise data
// RQ17 - read with gate low; write gate high
// RQ18 - strobes idle means device drives nothing
`timescale 1ns/10ps
`default_nettype none
module flash_host
  import flash_host_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [flash_host_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic byte_mode_in,
  input wire logic protect_in,
  input wire logic hw_reset_req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [flash_host_pkg::DATA_W-1:0] rsp_rdata_out,
  output logic busy_out,
  output logic [flash_host_pkg::ADDR_W-1:0] addr_out,
  output logic select_n_out,
  output logic out_gate_n_out,
  output logic write_strobe_n_out,
  output logic word_mode_out,
  output logic protect_n_out,
  output logic hw_reset_n_out,
  output logic [flash_host_pkg::DATA_W-2:0] data_out,
  output logic [flash_host_pkg::DATA_W-2:0] data_oe_out,
  input wire logic [flash_host_pkg::DATA_W-2:0] data_in,
  output logic data15_or_addr_lsb_out,
  output logic data15_or_addr_lsb_oe_out,
  input wire logic data15_or_addr_lsb_in,
  input wire logic op_in_progress_n_in
);
  import flash_host_pkg::*;

  host_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic sel_n_q, sel_n_d;
  logic oe_n_q, oe_n_d;
  logic we_n_q, we_n_d;
  logic word_q, word_d;
  logic wp_n_q, wp_n_d;
  logic rst_n_q, rst_n_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic drive_q, drive_d;
  logic lsb_q, lsb_d;
  logic busy_q, busy_d;
  logic top_oe_q, top_oe_d;
  logic top_val_q, top_val_d;
  logic [DATA_W-2:0] lane_oe_q, lane_oe_d;
  logic [DATA_W-1:0] pins_raw, pins_sync;
  logic busy_n_sync;

  // pins are asynchronous to clk_in: two flops before use
  assign pins_raw = {data15_or_addr_lsb_in, data_in};
  pin_sync #(.WIDTH(DATA_W + 1)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .async_in({op_in_progress_n_in, pins_raw}),
    .sync_out({busy_n_sync, pins_sync})
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ready_d = 1'b0;
    rsp_valid_d = 1'b0;
    rdata_d = rdata_q;
    addr_d = addr_q;
    sel_n_d = sel_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    word_d = word_q;
    wp_n_d = protect_in ? 1'b0 : 1'b1; // RQ15
    rst_n_d = rst_n_q;
    dout_d = dout_q;
    drive_d = drive_q;
    lsb_d = lsb_q;
    busy_d = ~busy_n_sync; // RQ13 RQ14
    case (state_q)
      ST_RESET: begin
        rst_n_d = 1'b0; // RQ7
        sel_n_d = 1'b1;
        oe_n_d = 1'b1;
        we_n_d = 1'b1;
        drive_d = 1'b0;
        if (cnt_q >= CNT_W'(RESET_PULSE_CYC)) begin
          rst_n_d = 1'b1;
          cnt_d = CNT_ZERO;
          state_d = ST_RELEASE;
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      ST_RELEASE: begin
        // later of the two release delays gates the first access
        if (cnt_q >= CNT_W'(RELEASE_CYC)) begin // RQ8
          state_d = ST_IDLE;
          ready_d = 1'b1;
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      ST_IDLE: begin
        ready_d = 1'b1;
        if (hw_reset_req_in) begin
          ready_d = 1'b0;
          cnt_d = CNT_ZERO;
          state_d = ST_RESET;
        end else if (req_valid_in) begin
          ready_d = 1'b0;
          // width is sampled per access and held until idle again
          word_d = ~byte_mode_in; // RQ5 RQ6
          addr_d = req_addr_in; // RQ1
          lsb_d = req_wdata_in[DATA_W-1];
          cnt_d = CNT_ZERO;
          sel_n_d = 1'b0;
          if (req_write_in) begin
            oe_n_d = 1'b1; // RQ17
            // strobe falls next cycle, once width, address and lsb have settled
            we_n_d = 1'b1; // RQ6
            dout_d = req_wdata_in; // RQ9
            drive_d = 1'b1;
            state_d = ST_WRITE_LOW;
          end else begin
            oe_n_d = 1'b0; // RQ3 RQ17
            drive_d = 1'b0;
            state_d = ST_READ;
          end
        end
      end
      ST_READ: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_q >= CNT_W'(READ_CYC + SYNC_STAGES)) begin
          rdata_d = pins_sync; // RQ9
          if (!word_q) begin
            rdata_d[DATA_W-1:BYTE_W] = '0; // RQ10 RQ11
          end
          rsp_valid_d = 1'b1;
          sel_n_d = 1'b1; // RQ2
          oe_n_d = 1'b1; // RQ18
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_WRITE_LOW: begin
        cnt_d = cnt_q + CNT_ONE;
        we_n_d = 1'b0; // RQ4 RQ16
        if (cnt_q >= CNT_W'(WPULSE_CYC)) begin
          we_n_d = 1'b1; // RQ4 RQ16
          sel_n_d = 1'b1;
          cnt_d = CNT_ZERO;
          state_d = ST_WRITE_HOLD;
        end
      end
      ST_WRITE_HOLD: begin
        cnt_d = cnt_q + CNT_ONE;
        if (cnt_q >= CNT_W'(WHOLD_CYC - 1)) begin
          drive_d = 1'b0;
          rsp_valid_d = 1'b1;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_RESET;
        cnt_d = CNT_ZERO;
      end
    endcase
    // top pin: address lsb in byte mode, data15 in word mode
    top_oe_d = ~word_d | drive_d; // RQ12
    top_val_d = word_d ? dout_d[DATA_W-1] : lsb_d; // RQ12
    // upper lanes unused for writes in byte mode
    lane_oe_d = {{(DATA_W-1-BYTE_W){drive_d & word_d}}, {BYTE_W{drive_d}}}; // RQ10
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= ST_RESET;
      cnt_q <= CNT_ZERO;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rdata_q <= '0;
      addr_q <= '0;
      sel_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      word_q <= 1'b1;
      wp_n_q <= 1'b1;
      rst_n_q <= 1'b0;
      dout_q <= '0;
      drive_q <= 1'b0;
      lsb_q <= 1'b0;
      busy_q <= 1'b0;
      top_oe_q <= 1'b0;
      top_val_q <= 1'b0;
      lane_oe_q <= '0;
    end else if (enable_in) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rdata_q <= rdata_d;
      addr_q <= addr_d;
      sel_n_q <= sel_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      word_q <= word_d;
      wp_n_q <= wp_n_d;
      rst_n_q <= rst_n_d;
      dout_q <= dout_d;
      drive_q <= drive_d;
      lsb_q <= lsb_d;
      busy_q <= busy_d;
      top_oe_q <= top_oe_d;
      top_val_q <= top_val_d;
      lane_oe_q <= lane_oe_d;
    end
  end

  assign req_ready_out = ready_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_rdata_out = rdata_q;
  assign busy_out = busy_q;
  assign addr_out = addr_q;
  assign select_n_out = sel_n_q;
  assign out_gate_n_out = oe_n_q;
  assign write_strobe_n_out = we_n_q;
  assign word_mode_out = word_q;
  assign protect_n_out = wp_n_q;
  assign hw_reset_n_out = rst_n_q;
  assign data_out = dout_q[DATA_W-2:0];
  assign data_oe_out = lane_oe_q; // RQ10
  assign data15_or_addr_lsb_out = top_val_q;
  assign data15_or_addr_lsb_oe_out = top_oe_q;
endmodule
`default_nettype wire

// ===== flash_host_properties.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_properties (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic select_n_out,
  input wire logic out_gate_n_out,
  input wire logic write_strobe_n_out,
  input wire logic word_mode_out,
  input wire logic hw_reset_n_out,
  input wire logic [flash_host_pkg::DATA_W-2:0] data_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence quiet_after;
    (select_n_out && write_strobe_n_out)[*5];
  endsequence
  write_gate_high_a: assert property (
    !write_strobe_n_out |-> out_gate_n_out) else $error("gate low in write");
  read_no_drive_a: assert property (
    !out_gate_n_out |-> write_strobe_n_out && !select_n_out && data_oe_out == '0)
    else $error("bad read cycle");
  width_steady_a: assert property (
    !write_strobe_n_out |-> $stable(word_mode_out)) else $error("width moved in write");
  reset_pulse_a: assert property (
    $rose(hw_reset_n_out) |-> !$past(hw_reset_n_out, 10)) else $error("reset pulse short");
  reset_quiet_a: assert property (
    !hw_reset_n_out |-> select_n_out && write_strobe_n_out) else $error("access in reset");
  release_wait_a: assert property (
    $rose(hw_reset_n_out) |-> quiet_after) else $error("access too soon");
endmodule
bind flash_host flash_host_properties props (.clk_in, .reset_in, .select_n_out,
  .out_gate_n_out, .write_strobe_n_out, .word_mode_out, .hw_reset_n_out, .data_oe_out);
`default_nettype wire

// ===== flash_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model (
  input wire logic clk_in,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
  input wire logic select_n_in,
  input wire logic out_gate_n_in,
  input wire logic write_strobe_n_in,
  input wire logic word_mode_in,
  input wire logic protect_n_in,
  input wire logic hw_reset_n_in,
  input wire logic [15:0] lanes_in,
  output logic [15:0] lanes_out,
  output logic [15:0] lanes_oe_out,
  output logic busy_n_out
);
  logic [15:0] w, cmd_data;
  logic [25:0] cmd_addr;
  int busy_cnt = 0;
  wire logic wr_n = select_n_in | write_strobe_n_in;
  wire logic [25:0] baddr = {addr_in, word_mode_in ? 1'b0 : lanes_in[15]};
  wire logic rd = hw_reset_n_in & !select_n_in & !out_gate_n_in & write_strobe_n_in;
  assign w = addr_in[15:0] ^ 16'h5A3C;
  assign lanes_out = word_mode_in ? w : {8'h00, lanes_in[15] ? w[15:8] : w[7:0]};
  assign lanes_oe_out = !rd ? 16'h0000 : word_mode_in ? 16'hFFFF : 16'h00FF;
  assign busy_n_out = busy_cnt == 0;
  always @(negedge wr_n) if (hw_reset_n_in === 1'b1) cmd_addr = baddr;
  // protected low block ignores writes
  always @(posedge wr_n) if (hw_reset_n_in === 1'b1 && (protect_n_in || cmd_addr[25:17] != 0)) begin
    cmd_data = word_mode_in ? lanes_in : {8'h00, lanes_in[7:0]};
    busy_cnt = 30;
  end
  always @(posedge clk_in) busy_cnt = (!hw_reset_n_in || busy_cnt == 0) ? 0 : busy_cnt - 1;
endmodule
`default_nettype wire

// ===== flash_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_tb;
  import flash_host_pkg::*;
  logic clk_in = 0, reset_in = 1, req_valid_in = 0, req_write_in = 0, flt = 0;
  logic byte_mode_in = 0, protect_in = 0, hw_reset_req_in = 0, busy_n;
  logic [ADDR_W-1:0] req_addr_in = '0, addr_out;
  logic [DATA_W-1:0] req_wdata_in = '0, rd, h_d, h_oe, d_d, d_oe, bus, rsp_rdata_out;
  logic req_ready_out, rsp_valid_out, busy_out, select_n_out, out_gate_n_out;
  logic write_strobe_n_out, word_mode_out, protect_n_out, hw_reset_n_out;
  logic [DATA_W-2:0] data_out, data_oe_out;
  logic data15_or_addr_lsb_out, data15_or_addr_lsb_oe_out;
  int n_errors = 0, compares = 0, cyc;
  always #5 clk_in = ~clk_in;
  // released lanes toggle so a stale value never looks valid
  always @(posedge clk_in) flt <= ~flt;
  assign h_d = {data15_or_addr_lsb_out, data_out};
  assign h_oe = {data15_or_addr_lsb_oe_out, data_oe_out};
  assign bus = (h_oe & h_d) | (d_oe & d_d) | (~h_oe & ~d_oe & {DATA_W{flt}});
  flash_host uut (.clk_in, .reset_in, .enable_in(1'b1), .req_valid_in, .req_write_in,
    .req_addr_in, .req_wdata_in, .byte_mode_in, .protect_in, .hw_reset_req_in,
    .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .busy_out, .addr_out, .select_n_out,
    .out_gate_n_out, .write_strobe_n_out, .word_mode_out, .protect_n_out, .hw_reset_n_out,
    .data_out, .data_oe_out, .data_in(bus[14:0]), .data15_or_addr_lsb_out,
    .data15_or_addr_lsb_oe_out, .data15_or_addr_lsb_in(bus[15]), .op_in_progress_n_in(busy_n));
  flash_dev_model dev (.clk_in, .addr_in(addr_out), .select_n_in(select_n_out),
    .out_gate_n_in(out_gate_n_out), .write_strobe_n_in(write_strobe_n_out),
    .word_mode_in(word_mode_out), .protect_n_in(protect_n_out), .hw_reset_n_in(hw_reset_n_out),
    .lanes_in(bus), .lanes_out(d_d), .lanes_oe_out(d_oe), .busy_n_out(busy_n));
  task automatic cmp(input string what, input logic [DATA_W-1:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_ready();
    cyc = 0;
    while (req_ready_out !== 1'b1) begin
      tick(1);
      cyc++;
    end
  endtask
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_valid_in = 1;
    wait_ready();
    tick(1);
    req_valid_in = 0;
    for (int i = 0; i < 50 && rsp_valid_out !== 1'b1; i++) tick(1);
    rd = rsp_rdata_out;
  endtask
  task automatic t_read();
    logic [15:0] w;
    w = 16'h1234 ^ 16'h5A3C;
    xfer(0, 25'h0001234, 16'h0000);
    cmp("word read", w, rd);
    cmp("width pin word", 16'h0001, {15'h0, word_mode_out});
    byte_mode_in = 1;
    for (int b = 0; b < 2; b++) begin
      xfer(0, 25'h0001234, {b[0], 15'h0000});
      cmp("byte read", {8'h00, b[0] ? w[15:8] : w[7:0]}, rd);
    end
    cmp("width pin byte", 16'h0000, {15'h0, word_mode_out});
  endtask
  task automatic t_write(input logic bm);
    byte_mode_in = bm;
    xfer(1, 25'h0000555, 16'hC3AA);
    cmp("cmd addr", bm ? 16'h0AAB : 16'h0AAA, dev.cmd_addr[15:0]);
    cmp("cmd data", bm ? 16'h00AA : 16'hC3AA, dev.cmd_data);
    tick(3);
    cmp("busy seen", 16'h0001, {15'h0, busy_out});
    tick(40);
    cmp("busy gone", 16'h0000, {15'h0, busy_out});
  endtask
  task automatic t_hw_reset();
    hw_reset_req_in = 1;
    for (int i = 0; i < 20 && hw_reset_n_out !== 1'b0; i++) tick(1);
    hw_reset_req_in = 0;
    wait_ready();
    cmp("reset wait", 16'h0001, {15'h0, cyc >= RESET_PULSE_CYC + RELEASE_CYC});
  endtask
  task automatic t_protect();
    protect_in = 1;
    tick(3);
    cmp("protect pin", 16'h0000, {15'h0, protect_n_out});
    protect_in = 0;
    tick(3);
  endtask
  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    tick(8);
    reset_in = 0;
    cmp("pin reset low", 16'h0000, {15'h0, hw_reset_n_out});
    wait_ready();
    cmp("release wait", 16'h0001, {15'h0, cyc >= RESET_PULSE_CYC + RELEASE_CYC});
    t_read();
    t_write(0);
    t_write(1);
    t_hw_reset();
    t_protect();
    finish_test();
  end
endmodule
`default_nettype wire
